// ### hw/fpl_pkg.sv
// Purpose: Shared constants and carriers for the perpendicular/lock state block
// Assumes: 32-bit AHB-Lite register port, 100 MHz clk_sys
// Notes: Byte counts are in bytes of the recorded field
package fpl_pkg;
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_LOCK = 8'h04;
    localparam logic [7:0] OFS_CONFIG = 8'h08;
    localparam logic [7:0] OFS_CTRL = 8'h0c;
    localparam logic [7:0] OFS_TIMING = 8'h10;
    localparam logic [7:0] OFS_DUMP8 = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    // Mode register fields
    localparam int MODE_GAP_BIT = 0;
    localparam int MODE_WGS_BIT = 1;
    localparam int MODE_FLAG_LSB = 2;
    localparam int MODE_OVERWRITE_BIT = 7;
    // Config register fields
    localparam int CFG_THR_LSB = 0;
    localparam int CFG_FDIS_BIT = 4;
    localparam int CFG_TRK_LSB = 8;
    // Control register fields
    localparam int CTRL_SWRST_BIT = 0;
    localparam int CTRL_RATE_LSB = 1;
    localparam int CTRL_DRIVE_LSB = 4;
    localparam int CTRL_PRECOMP_LSB = 8;
    localparam int CTRL_COMPAT_BIT = 12;
    localparam int CTRL_ENC_BIT = 13;
    // Timing register fields
    localparam int TIM_VCO_LSB = 0;
    localparam int TIM_WGAP_LSB = 8;
    localparam int TIM_GAP2_LSB = 16;
    localparam int TIM_PRECOMP_LSB = 24;
    // Dump byte eight fields
    localparam int DUMP_LOCK_BIT = 7;
    // Reset values
    localparam logic DEF_FIFO_DISABLE = 1'b1;
    localparam logic [3:0] DEF_FIFO_THRESHOLD = 4'h0;
    localparam logic [7:0] DEF_PRECOMP_TRACK = 8'h00;
    localparam logic [2:0] DEF_PRECOMP = 3'h0;
    // Field byte counts
    localparam logic [7:0] VCO_CONV_BYTES = 8'h18;
    localparam logic [7:0] VCO_PERP1M_BYTES = 8'h2b;
    localparam logic [7:0] WGAP_CONV_BYTES = 8'h00;
    localparam logic [7:0] WGAP_PERP1M_BYTES = 8'h26;
    localparam logic [7:0] WGAP_PERP500K_BYTES = 8'h13;
    localparam logic [7:0] GAP2_CONV_BYTES = 8'h16;
    localparam logic [7:0] GAP2_PERP1M_BYTES = 8'h29;
    localparam logic [2:0] PRECOMP_ZERO = 3'h0;
    // Data rate codes
    localparam logic [2:0] RATE_500K = 3'h0;
    localparam logic [2:0] RATE_1M = 3'h3;
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

    typedef struct packed {
        logic [7:0] vco_bytes;
        logic [7:0] wgap_bytes;
        logic [7:0] gap2_bytes;
        logic [2:0] precomp;
        logic perp;
    } fpl_timing_s;

    typedef struct packed {
        logic gap_select;
        logic write_gate_select;
        logic [3:0] drive_perp_flags;
    } fpl_mode_s;
endpackage

// ### hw/fpl_timing_sel.sv
// Purpose: Combinational choice of Gap2, VCO and write-gate timing per access
// Assumes: Inputs come from registered state on the same clock
// Notes: Reserved mode code behaves as conventional
`timescale 1ns/1ps
module fpl_timing_sel
    import fpl_pkg::*;
(
    input wire fpl_pkg::fpl_mode_s mode,
    input wire logic [1:0] drive_sel,
    input wire logic [2:0] data_rate,
    input wire logic [2:0] precomp_set,
    output fpl_pkg::fpl_timing_s timing
);
    import fpl_pkg::*;

    logic mode_any;
    logic flag_perp;

    always_comb begin
        mode_any = mode.gap_select | mode.write_gate_select;
        flag_perp = ~mode_any & mode.drive_perp_flags[drive_sel];
        timing.gap2_bytes = GAP2_CONV_BYTES;
        timing.vco_bytes = VCO_CONV_BYTES;
        timing.wgap_bytes = WGAP_CONV_BYTES;
        timing.precomp = precomp_set;
        timing.perp = 1'b0;
        if (mode.gap_select && mode.write_gate_select) begin
            timing.gap2_bytes = GAP2_PERP1M_BYTES;
            timing.vco_bytes = VCO_PERP1M_BYTES;
            timing.wgap_bytes = WGAP_PERP1M_BYTES;
            timing.perp = 1'b1;
        end else if (mode.gap_select) begin
            timing.wgap_bytes = WGAP_PERP500K_BYTES;
            timing.perp = 1'b1;
        end else if (flag_perp) begin
            timing.perp = 1'b1;
            timing.precomp = PRECOMP_ZERO;
            if (data_rate == RATE_1M) begin
                timing.wgap_bytes = WGAP_PERP1M_BYTES;
            end else begin
                timing.wgap_bytes = WGAP_PERP500K_BYTES;
            end
        end
    end
endmodule

// ### hw/fpl_core.sv
// Purpose: Perpendicular mode, per-drive flags and parameter lock state with AHB-Lite access
// Assumes: Single clk_sys at 100 MHz, synchronous active-low nrst is the hardware reset
// Notes: Software reset is a self-clearing control bit; always zero wait states
//
// Summary of operation
// - Reset leaves conventional mode with both mode bits zero.
// - Conventional read enables oscillator 24 bytes into Gap2.
// - 1 Mbps perpendicular read enables oscillator 43 bytes into Gap2.
// - Conventional write opens write gate at sync, zero Gap2 bytes.
// - 1 Mbps perpendicular write writes 38 Gap2 bytes before sync.
// - 500 Kbps perpendicular write writes 19 Gap2 bytes before sync.
// - Gap2 is 41 bytes in 1 Mbps perpendicular, else 22.
// - With mode bits zero, flagged drives act perpendicular automatically.
// - Flagged drive write Gap2 portion follows the programmed data rate.
// - Flagged drives get zero precompensation; others get programmed value.
// - Per-drive flags update only when the overwrite bit is one.
// - Either mode bit set makes the per-drive flags ignored.
// - Software reset clears the mode bits, flags kept.
// - Hardware reset clears mode bits and all per-drive flags.
// - While locked, software reset keeps FIFO and precomp track parameters.
// - Hardware reset clears lock and restores FIFO and track defaults.
// - Lock command returns one result byte holding the new lock bit.
// - Dump byte eight carries lock bit, mode bits and drive flags.
// - Compatibility mode is latched from select and encoding bits after hardware reset has cleared them, so compat_mode is always 0.
// - Defaults: FIFO disabled, threshold one byte, precomp from track zero.
//
// Our own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
module fpl_core
    import fpl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic [7:0] vco_enable_bytes,
    output logic [7:0] write_gate_select_bytes,
    output logic [7:0] gap2_format_bytes,
    output logic [2:0] precomp_select,
    output logic perp_active,
    output logic fifo_disable,
    output logic [3:0] fifo_threshold,
    output logic [7:0] precomp_start_track,
    output logic param_lock,
    output logic [1:0] compat_mode
);
    import fpl_pkg::*;

    typedef struct packed {
        fpl_mode_s mode;
        logic lock;
        logic fifo_dis;
        logic [3:0] thr;
        logic [7:0] trk;
        logic [2:0] rate;
        logic [1:0] drive;
        logic [2:0] precomp;
        logic compat_sel;
        logic enc_bit;
        logic [1:0] compat;
        logic hw_done;
        logic [7:0] lock_result;
        logic lock_result_valid;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
        fpl_timing_s tim;
    } fpl_state_s;

    fpl_state_s st;
    fpl_state_s next_st;
    fpl_timing_s tim_now;

    function automatic logic [7:0] dump_byte8(input fpl_state_s s);
        dump_byte8 = {s.lock, 1'b0, s.mode.drive_perp_flags,
            s.mode.write_gate_select, s.mode.gap_select};
    endfunction

    function automatic logic [31:0] read_mux(input fpl_state_s s, input logic [7:0] a);
        read_mux = 32'h0000_0000;
        case (a)
            OFS_MODE: read_mux = {26'h000_0000, s.mode.drive_perp_flags,
                s.mode.write_gate_select, s.mode.gap_select};
            OFS_LOCK: read_mux = {23'h00_0000, s.lock_result_valid, s.lock_result};
            OFS_CONFIG: read_mux = {16'h0000, s.trk, 3'h0, s.fifo_dis, s.thr};
            OFS_CTRL: read_mux = {18'h0_0000, s.enc_bit, s.compat_sel, 1'b0, s.precomp,
                2'h0, s.drive, s.rate, 1'b0};
            OFS_TIMING: read_mux = {5'h00, s.tim.precomp, s.tim.gap2_bytes,
                s.tim.wgap_bytes, s.tim.vco_bytes};
            OFS_DUMP8: read_mux = {24'h00_0000, dump_byte8(s)};
            OFS_STATUS: read_mux = {27'h000_0000, s.tim.perp, s.compat, s.lock, s.hw_done};
            default: read_mux = 32'h0000_0000;
        endcase
    endfunction

    fpl_timing_sel u_timing_sel (
        .mode(st.mode),
        .drive_sel(st.drive),
        .data_rate(st.rate),
        .precomp_set(st.precomp),
        .timing(tim_now)
    );

    always_comb begin
        logic take;
        logic [31:0] wd;
        take = 1'b0;
        wd = hwdata;
        next_st = st;
        next_st.tim = tim_now;
        next_st.hw_done = 1'b1;
        if (!st.hw_done) begin
            // Strap-like bits latched once after hardware reset release
            next_st.compat = {st.enc_bit, st.compat_sel};
        end
        take = hsel && hready && (htrans == HTRANS_NONSEQ);
        if (st.wr_pend) begin
            next_st.wr_pend = 1'b0;
            case (st.wr_addr)
                OFS_MODE: begin
                    next_st.mode.gap_select = wd[MODE_GAP_BIT];
                    next_st.mode.write_gate_select = wd[MODE_WGS_BIT];
                    if (wd[MODE_OVERWRITE_BIT]) begin
                        next_st.mode.drive_perp_flags = wd[MODE_FLAG_LSB +: 4];
                    end
                end
                OFS_LOCK: begin
                    next_st.lock = wd[DUMP_LOCK_BIT];
                    next_st.lock_result = {3'h0, wd[DUMP_LOCK_BIT], 4'h0};
                    next_st.lock_result_valid = 1'b1;
                end
                OFS_CONFIG: begin
                    next_st.thr = wd[CFG_THR_LSB +: 4];
                    next_st.fifo_dis = wd[CFG_FDIS_BIT];
                    next_st.trk = wd[CFG_TRK_LSB +: 8];
                end
                OFS_CTRL: begin
                    next_st.rate = wd[CTRL_RATE_LSB +: 3];
                    next_st.drive = wd[CTRL_DRIVE_LSB +: 2];
                    next_st.precomp = wd[CTRL_PRECOMP_LSB +: 3];
                    next_st.compat_sel = wd[CTRL_COMPAT_BIT];
                    next_st.enc_bit = wd[CTRL_ENC_BIT];
                    if (wd[CTRL_SWRST_BIT]) begin
                        next_st.mode.gap_select = 1'b0;
                        next_st.mode.write_gate_select = 1'b0;
                        if (!st.lock) begin
                            next_st.fifo_dis = DEF_FIFO_DISABLE;
                            next_st.thr = DEF_FIFO_THRESHOLD;
                            next_st.trk = DEF_PRECOMP_TRACK;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        if (take) begin
            next_st.wr_pend = hwrite;
            next_st.wr_addr = haddr[7:0];
            if (!hwrite) begin
                next_st.rdata = read_mux(st, haddr[7:0]);
                // A result arriving in the same cycle wins over the read clear
                if (haddr[7:0] == OFS_LOCK && !(st.wr_pend && st.wr_addr == OFS_LOCK)) begin
                    next_st.lock_result_valid = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            st <= '0;
            st.lock <= 1'b0;
            st.fifo_dis <= DEF_FIFO_DISABLE;
            st.thr <= DEF_FIFO_THRESHOLD;
            st.trk <= DEF_PRECOMP_TRACK;
            st.precomp <= DEF_PRECOMP;
            st.rate <= RATE_500K;
            st.tim.vco_bytes <= VCO_CONV_BYTES;
            st.tim.gap2_bytes <= GAP2_CONV_BYTES;
        end else begin
            st <= next_st;
        end
    end

    always_comb begin
        hrdata = st.rdata;
        hreadyout = 1'b1;
        hresp = 1'b0;
        vco_enable_bytes = st.tim.vco_bytes;
        write_gate_select_bytes = st.tim.wgap_bytes;
        gap2_format_bytes = st.tim.gap2_bytes;
        precomp_select = st.tim.precomp;
        perp_active = st.tim.perp;
        fifo_disable = st.fifo_dis;
        fifo_threshold = st.thr;
        precomp_start_track = st.trk;
        param_lock = st.lock;
        compat_mode = st.compat;
    end

    reset_conv_a: assert property (@(posedge clk_sys) $rose(nrst) |->
        !st.mode.gap_select && !st.mode.write_gate_select && st.mode.drive_perp_flags == 4'h0)
        else $error("mode bits not clear after reset");
    hw_reset_lock_a: assert property (@(posedge clk_sys) !nrst |=>
        !param_lock && fifo_disable && fifo_threshold == 4'h0 && precomp_start_track == 8'h00)
        else $error("hardware reset defaults wrong");
    flag_overwrite_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        st.wr_pend && st.wr_addr == OFS_MODE && !hwdata[MODE_OVERWRITE_BIT] |=>
        $stable(st.mode.drive_perp_flags))
        else $error("flags changed without overwrite");
    mode_bits_upd_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        st.wr_pend && st.wr_addr == OFS_MODE |=>
        st.mode.gap_select == $past(hwdata[MODE_GAP_BIT]) &&
        st.mode.write_gate_select == $past(hwdata[MODE_WGS_BIT]))
        else $error("mode bit not written");
    swrst_keep_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        st.wr_pend && st.wr_addr == OFS_CTRL && hwdata[CTRL_SWRST_BIT] |=>
        !st.mode.gap_select && !st.mode.write_gate_select && $stable(st.mode.drive_perp_flags)
        && $stable(param_lock))
        else $error("software reset effect wrong");
    lock_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        st.wr_pend && st.wr_addr == OFS_CTRL && hwdata[CTRL_SWRST_BIT] && param_lock |=>
        $stable(precomp_start_track) && $stable(fifo_threshold) && $stable(fifo_disable))
        else $error("locked parameters lost");
    gap2_len_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        ##1 (gap2_format_bytes == (($past(st.mode.gap_select) &&
        $past(st.mode.write_gate_select)) ? GAP2_PERP1M_BYTES : GAP2_CONV_BYTES)))
        else $error("gap2 length wrong");
    vco_time_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        st.mode.gap_select && st.mode.write_gate_select |=> vco_enable_bytes == VCO_PERP1M_BYTES)
        else $error("vco enable not at 43");
    flag_precomp_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        !st.mode.gap_select && !st.mode.write_gate_select &&
        st.mode.drive_perp_flags[st.drive] |=> precomp_select == PRECOMP_ZERO && perp_active)
        else $error("flagged drive precomp not zero");
    flag_ignore_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        st.mode.write_gate_select && !st.mode.gap_select |=>
        !perp_active && write_gate_select_bytes == WGAP_CONV_BYTES)
        else $error("flags not ignored in reserved mode");
    wgap_500k_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        st.mode.gap_select && !st.mode.write_gate_select |=>
        write_gate_select_bytes == WGAP_PERP500K_BYTES)
        else $error("500k gap2 write portion wrong");
    lock_result_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        st.wr_pend && st.wr_addr == OFS_LOCK |=>
        st.lock_result[4] == param_lock && st.lock_result_valid)
        else $error("lock result byte wrong");
    dump_lock_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        hsel && hready && htrans == HTRANS_NONSEQ && !hwrite && haddr[7:0] == OFS_DUMP8 |=>
        hrdata[DUMP_LOCK_BIT] == $past(param_lock) &&
        hrdata[MODE_FLAG_LSB +: 4] == $past(st.mode.drive_perp_flags))
        else $error("dump byte lock mismatch");
endmodule

// ### tb/fpl_drive_head.sv
// Purpose: Drive model with a pre-erase head that trails the write head
// Assumes: rate_1m is the density the drive records at
// Notes: pre_erase_ok is high when the written Gap2 portion equals the pre-erase lag
`timescale 1ns/1ps
module fpl_drive_head (
    input wire logic rate_1m,
    input wire logic perp_active,
    input wire logic [7:0] write_gate_select_bytes,
    output logic pre_erase_ok
);
    logic [7:0] need;
    always_comb begin
        // Lag is 38 bytes at 1 Mbps, half that at 500 Kbps
        need = !perp_active ? 8'h00 : (rate_1m ? 8'h26 : 8'h13);
        pre_erase_ok = write_gate_select_bytes == need;
    end
endmodule

// ### tb/fdc_perpendicular_lock_state_test.sv
// Purpose: Self-checking bench for the perpendicular mode and lock state block
// Assumes: Zero-wait AHB-Lite slave, 100 MHz clk_sys, synchronous nrst
// Notes: Expected read values are queued by the driver and compared by a watcher
`timescale 1ns/1ps
module fdc_perpendicular_lock_state_test;
    import fpl_pkg::*;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic rate_1m = 1'b0;
    logic [31:0] hrdata, seen, cfg;
    logic [31:0] rnd = 32'h24cc;
    logic hreadyout, hresp, perp_active, fifo_disable, param_lock, pre_erase_ok;
    logic [7:0] wgap_b, vco_b, gap2_b, trk_b;
    logic [3:0] fl, thr_b;
    logic [2:0] pc_b;
    logic [1:0] compat_mode;
    logic [63:0] notes[$];
    logic [63:0] note;
    int err_total = 0;
    int checked = 0;
    event got;

    always #5 clk_sys = ~clk_sys;

    fpl_core uut (
        .clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .vco_enable_bytes(vco_b),
        .write_gate_select_bytes(wgap_b), .gap2_format_bytes(gap2_b), .precomp_select(pc_b),
        .perp_active(perp_active), .fifo_disable(fifo_disable), .fifo_threshold(thr_b),
        .precomp_start_track(trk_b), .param_lock(param_lock), .compat_mode(compat_mode)
    );

    fpl_drive_head head (
        .rate_1m(rate_1m), .perp_active(perp_active),
        .write_gate_select_bytes(wgap_b), .pre_erase_ok(pre_erase_ok)
    );

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
        checked++;
        if (seen_v !== exp_v) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen_v, exp_v);
        end
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Waits for the edge at which hready is sampled high
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                err_total++;
                summarize();
            end
            @(posedge clk_sys);
        end
    endtask

    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wr ? d : 32'h0;
        wait_rdy();
        seen = hrdata;
        if (!wr) begin
            ->got;
        end
        // Let register and derived outputs settle before the next access
        repeat (2) @(posedge clk_sys);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        notes.push_back({m, e & m});
        xfer(1'b0, a, 32'h0);
    endtask

    initial begin
        forever begin
            @(got);
            if (notes.size() == 0) begin
                check(seen, 32'hdead);
            end else begin
                note = notes.pop_front();
                check(seen & note[63:32], note[31:0]);
                check({31'h0, hresp}, 32'h0);
            end
        end
    end

    initial begin
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        rd(OFS_TIMING, {5'h0, DEF_PRECOMP, GAP2_CONV_BYTES, 8'h0, VCO_CONV_BYTES}, '1);
        rd(OFS_CONFIG, 32'h10, '1);
        rd(OFS_DUMP8, 32'h0, '1);
        rd(OFS_STATUS, 32'h1, '1);
        check({30'h0, compat_mode}, 32'h0);
        rate_1m <= 1'b1;
        xfer(1'b1, OFS_CTRL, 32'h506);
        for (int m = 0; m < 4; m++) begin
            xfer(1'b1, OFS_MODE, {30'h0, m[1:0]});
            rd(OFS_TIMING, {5'h0, 3'h5, m == 3 ? GAP2_PERP1M_BYTES : GAP2_CONV_BYTES,
                m == 3 ? WGAP_PERP1M_BYTES : (m == 1 ? WGAP_PERP500K_BYTES : 8'h0),
                m == 3 ? VCO_PERP1M_BYTES : VCO_CONV_BYTES}, '1);
            check({31'h0, perp_active}, {31'h0, m == 1 || m == 3});
            check({31'h0, pre_erase_ok}, {31'h0, m != 1});
            check({24'h0, gap2_b}, {24'h0, m == 3 ? GAP2_PERP1M_BYTES : GAP2_CONV_BYTES});
            check({24'h0, vco_b}, {24'h0, m == 3 ? VCO_PERP1M_BYTES : VCO_CONV_BYTES});
        end
        rnd = xs(rnd);
        fl = {rnd[3:2], 2'b01};
        xfer(1'b1, OFS_MODE, {24'h0, 1'b1, 1'b0, fl, 2'b00});
        rd(OFS_DUMP8, {26'h0, fl, 2'b00}, '1);
        for (int d = 0; d < 4; d++) begin
            for (int r = 0; r < 2; r++) begin
                rate_1m <= r[0];
                xfer(1'b1, OFS_CTRL, {21'h0, 3'h5, 2'b00, d[1:0], r[0] ? RATE_1M : RATE_500K, 1'b0});
                rd(OFS_TIMING, {5'h0, fl[d] ? PRECOMP_ZERO : 3'h5, GAP2_CONV_BYTES,
                    fl[d] ? (r[0] ? WGAP_PERP1M_BYTES : WGAP_PERP500K_BYTES) : 8'h0, 8'h0},
                    32'hffffff00);
                check({31'h0, perp_active}, {31'h0, fl[d]});
                check({29'h0, pc_b}, {29'h0, fl[d] ? PRECOMP_ZERO : 3'h5});
                check({31'h0, pre_erase_ok}, 32'h1);
            end
        end
        xfer(1'b1, OFS_MODE, 32'h3f);
        rd(OFS_DUMP8, {26'h0, fl, 2'b11}, '1);
        rd(OFS_TIMING, {8'h5, GAP2_PERP1M_BYTES, WGAP_PERP1M_BYTES, VCO_PERP1M_BYTES}, '1);
        rnd = xs(rnd);
        cfg = {16'h0, rnd[15:8], 4'h0, rnd[3:0]};
        xfer(1'b1, OFS_CONFIG, cfg);
        xfer(1'b1, OFS_LOCK, 32'h80);
        rd(OFS_LOCK, 32'h110, 32'h1ff);
        rd(OFS_LOCK, 32'h0, 32'h100);
        xfer(1'b1, OFS_CTRL, 32'h1);
        rd(OFS_CONFIG, cfg, 32'hffff);
        check({20'h0, trk_b, thr_b}, {20'h0, cfg[15:8], cfg[3:0]});
        rd(OFS_DUMP8, {24'h0, 2'b10, fl, 2'b00}, '1);
        check({31'h0, param_lock}, 32'h1);
        xfer(1'b1, OFS_LOCK, 32'h0);
        rd(OFS_LOCK, 32'h100, 32'h110);
        xfer(1'b1, OFS_CTRL, 32'h1);
        rd(OFS_CONFIG, 32'h10, 32'hffff);
        check({31'h0, fifo_disable}, 32'h1);
        xfer(1'b1, OFS_LOCK, 32'h80);
        xfer(1'b1, OFS_CONFIG, cfg);
        nrst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        rd(OFS_DUMP8, 32'h0, '1);
        rd(OFS_CONFIG, 32'h10, 32'hffff);
        check({20'h0, trk_b, thr_b}, {20'h0, DEF_PRECOMP_TRACK, DEF_FIFO_THRESHOLD});
        check({31'h0, param_lock}, 32'h0);
        check({30'h0, compat_mode}, 32'h0);
        xfer(1'b1, 8'h40, 32'hffffffff);
        rd(8'h40, 32'h0, '1);
        summarize();
    end
endmodule
